// ### hw/optical_pulse_front_end_ctrl.sv
// Light-pulse timing, transimpedance stepping and near/far parameter selection for the front end.
// Assumes an AXI4-Lite master, filtered comparator levels synchronous to core_clk, one clock.
// Assumes the host reruns power-on init mode through the control register after a step change.
//
// Overview of operation
// - Bit 0 of pulse register reads 1 only for good current in low-side mode.
// - Emitter current monitor is used only in low-side drive operation.
// - Rate code 1/2/3 gives 13.9/10.4/5 kHz pulses; code 0 reserved, no pulses.
// - Pulse width is 2 us plus 0.5 us per width code.
// - Static modes never change the transimpedance step.
// - Automatic mode loads programmed step on entering power-on init mode.
// - Automatic mode steps one up or down on sum-current monitor crossings.
// - Far set applies while switching state off, near set while on.
// - Active 7-bit split point assigns diodes to near channel, rest to far.
// - Active 8-bit gain ratio drives the subtractor potentiometer.
// - Near signal above far signal marks near range and switching on.
// - Hysteresis of all comparators follows filtered outputs, not raw ones.
// - Difference hysteresis comes from bits 3:0 of impedance register.
// - Shared sum hysteresis comes from bits 7:6 of sum hysteresis register.
// - Disable bit set removes all comparator hysteresis.
// - Sum comparator outputs go low below their thresholds.
//
// Design decision made here: register access over AXI4-Lite.
`include "optical_front_end_defines.svh"

module optical_pulse_front_end_ctrl #(
  parameter int PW_BITS = 4,
  parameter int CNT_BITS = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analogue front-end status
  input wire logic emitterCurrentSense,
  input wire logic diffComparatorFiltered,
  input wire logic warnComparatorFiltered,
  input wire logic faultComparatorFiltered,
  input wire logic sumCurrentHigh,
  input wire logic sumCurrentLow,
  // Emitter and analogue controls
  output logic emitterDrivePin,
  output logic [1:0] transimpedanceSel,
  output optical_front_end_pkg::param_set_s activeParams,
  output optical_front_end_pkg::hys_ctrl_s diffHysteresis,
  output optical_front_end_pkg::hys_ctrl_s sumHysteresis,
  output logic nearRange
);

  // ========================================================================
  // Timing constants derived from the clock period
  // Integer division truncates each count toward zero
  localparam logic [CNT_BITS-1:0] PW_BASE_CYC = CNT_BITS'(`PW_BASE_NS / `CLK_NS);
  localparam logic [CNT_BITS-1:0] PW_STEP_CYC = CNT_BITS'(`PW_STEP_NS / `CLK_NS);
  localparam logic [CNT_BITS-1:0] PERIOD1_CYC = CNT_BITS'(`PERIOD1_NS / `CLK_NS);
  localparam logic [CNT_BITS-1:0] PERIOD2_CYC = CNT_BITS'(`PERIOD2_NS / `CLK_NS);
  localparam logic [CNT_BITS-1:0] PERIOD3_CYC = CNT_BITS'(`PERIOD3_NS / `CLK_NS);

  // ========================================================================
  // Whole block state
  typedef struct packed {
    // Write channel
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;

    // Read channel
    logic arReady;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;

    // Software configuration
    logic [6:0] farSplit;
    logic [7:0] farGain;
    logic [6:0] nearSplit;
    logic [7:0] nearGain;
    logic [7:0] impHys;
    logic [1:0] sumHysSel;
    logic [5:0] pulseCfg;
    logic lowSideMode;
    logic initPulse;

    // Live status
    logic [1:0] step;
    logic currentGood;

    // Pulse generator
    optical_front_end_pkg::pulse_state_e pgState;
    logic [CNT_BITS-1:0] pgCount;
    logic [CNT_BITS-1:0] periodCount;

    // Registered analogue controls
    logic drive;
    logic [1:0] tiSel;
    optical_front_end_pkg::param_set_s params;
    optical_front_end_pkg::hys_ctrl_s diffHys;
    optical_front_end_pkg::hys_ctrl_s sumHys;
    logic near;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  // ========================================================================
  // Rate code to period in cycles; zero for the reserved code
  function automatic logic [CNT_BITS-1:0] periodOf(input logic [1:0] code);
    case (code)
      2'h1: periodOf = PERIOD1_CYC;
      2'h2: periodOf = PERIOD2_CYC;
      2'h3: periodOf = PERIOD3_CYC;
      default: periodOf = '0;
    endcase
  endfunction

  // ========================================================================
  // Next-state logic
  always_comb
  begin
    logic doWrite;
    logic [7:0] wByte;
    logic [CNT_BITS-1:0] pwCyc;
    logic [CNT_BITS-1:0] period;
    nxt_ff = cur_ff;
    doWrite = 1'b0;
    wByte = 8'h00;
    pwCyc = '0;
    period = '0;
    nxt_ff.initPulse = 1'b0;

    // Write channel: capture address and data in either order
    if (s_axi_awvalid && cur_ff.awReady)
    begin
      nxt_ff.awHeld = 1'b1;
      nxt_ff.awAddr = s_axi_awaddr;
      nxt_ff.awReady = 1'b0;
    end
    // Data may arrive before, with or after its address
    if (s_axi_wvalid && cur_ff.wReady)
    begin
      nxt_ff.wHeld = 1'b1;
      nxt_ff.wData = s_axi_wdata;
      nxt_ff.wStrb = s_axi_wstrb;
      nxt_ff.wReady = 1'b0;
    end

    // Both halves held: store the low byte when its strobe bit 0 is set, and answer
    if (cur_ff.awHeld && cur_ff.wHeld && !cur_ff.bValid)
    begin
      doWrite = cur_ff.wStrb[0];
      wByte = cur_ff.wData[7:0];
      nxt_ff.awHeld = 1'b0;
      nxt_ff.wHeld = 1'b0;
      nxt_ff.bValid = 1'b1;
      nxt_ff.bResp = `AXI_OKAY;
      // Unmapped byte addresses answer with an error
      case (cur_ff.awAddr)
        `OFS_FAR_SPLIT,
        `OFS_FAR_GAIN,
        `OFS_NEAR_SPLIT,
        `OFS_NEAR_GAIN,
        `OFS_IMP_HYS,
        `OFS_SUM_HYS,
        `OFS_PULSE,
        `OFS_FRONT_CTRL,
        `OFS_FRONT_STAT: nxt_ff.bResp = `AXI_OKAY;
        default: nxt_ff.bResp = `AXI_SLVERR;
      endcase
    end

    // Response taken: reopen both write channels
    if (cur_ff.bValid && s_axi_bready)
    begin
      nxt_ff.bValid = 1'b0;
      nxt_ff.awReady = 1'b1;
      nxt_ff.wReady = 1'b1;
    end

    // Register stores; status bits are never written
    if (doWrite)
    begin
      case (cur_ff.awAddr)
        `OFS_FAR_SPLIT: nxt_ff.farSplit = wByte[6:0];
        `OFS_FAR_GAIN: nxt_ff.farGain = wByte;
        `OFS_NEAR_SPLIT: nxt_ff.nearSplit = wByte[6:0];
        `OFS_NEAR_GAIN: nxt_ff.nearGain = wByte;
        `OFS_IMP_HYS: nxt_ff.impHys = wByte;
        `OFS_SUM_HYS: nxt_ff.sumHysSel = wByte[`SUM_HYSTERESIS_MSB:`SUM_HYSTERESIS_LSB];
        `OFS_PULSE: nxt_ff.pulseCfg = wByte[`PER_MSB:`PW_LSB];
        // Own control register: drive mode and init request
        `OFS_FRONT_CTRL:
        begin
          nxt_ff.lowSideMode = wByte[`CTRL_LOWSIDE_BIT];
          nxt_ff.initPulse = wByte[`CTRL_INIT_BIT];
        end
        default: nxt_ff.lowSideMode = cur_ff.lowSideMode;
      endcase
    end

    // Read channel
    if (s_axi_arvalid && cur_ff.arReady)
    begin
      nxt_ff.arReady = 1'b0;
      nxt_ff.rValid = 1'b1;
      nxt_ff.rResp = `AXI_OKAY;
      nxt_ff.rData = 32'h0000_0000;
      // Unmapped addresses read zero and answer with an error
      case (s_axi_araddr)
        `OFS_FAR_SPLIT: nxt_ff.rData[6:0] = cur_ff.farSplit;
        `OFS_FAR_GAIN: nxt_ff.rData[7:0] = cur_ff.farGain;
        `OFS_NEAR_SPLIT: nxt_ff.rData[6:0] = cur_ff.nearSplit;
        `OFS_NEAR_GAIN: nxt_ff.rData[7:0] = cur_ff.nearGain;
        `OFS_IMP_HYS: nxt_ff.rData[7:0] = cur_ff.impHys;
        `OFS_SUM_HYS: nxt_ff.rData[`SUM_HYSTERESIS_MSB:`SUM_HYSTERESIS_LSB] = cur_ff.sumHysSel;
        `OFS_PULSE:
        begin
          nxt_ff.rData[`PER_MSB:`PW_LSB] = cur_ff.pulseCfg;
          nxt_ff.rData[`PULSE_OK_BIT] = cur_ff.currentGood;
        end
        `OFS_FRONT_CTRL: nxt_ff.rData[`CTRL_LOWSIDE_BIT] = cur_ff.lowSideMode;
        `OFS_FRONT_STAT: nxt_ff.rData[3:0] = {cur_ff.near, cur_ff.step, cur_ff.currentGood};
        default: nxt_ff.rResp = `AXI_SLVERR;
      endcase
    end

    // Read data taken: reopen the address channel
    if (cur_ff.rValid && s_axi_rready)
    begin
      nxt_ff.rValid = 1'b0;
      nxt_ff.arReady = 1'b1;
    end

    // Current good only in low-side mode, sampled at the end of each pulse
    if (!cur_ff.lowSideMode)
      nxt_ff.currentGood = 1'b0;
    else if (cur_ff.pgState == optical_front_end_pkg::PG_ON && cur_ff.pgCount == '0)
      nxt_ff.currentGood = emitterCurrentSense;

    // Pulse generator: width then remainder of period
    pwCyc = CNT_BITS'(PW_BASE_CYC
      + PW_STEP_CYC * CNT_BITS'(cur_ff.pulseCfg[`PW_LSB +: PW_BITS]));
    period = periodOf(cur_ff.pulseCfg[`PER_MSB:`PER_LSB]);
    case (cur_ff.pgState)
      // Idle: start a period unless the rate code is reserved
      optical_front_end_pkg::PG_IDLE:
      begin
        nxt_ff.drive = 1'b0;
        if (period != '0)
        begin
          nxt_ff.pgState = optical_front_end_pkg::PG_ON;
          nxt_ff.drive = 1'b1;
          nxt_ff.pgCount = CNT_BITS'(pwCyc - 1'b1);
          nxt_ff.periodCount = CNT_BITS'(period - 1'b1);
        end
      end

      // Light on for the width, period counter running
      optical_front_end_pkg::PG_ON:
      begin
        nxt_ff.pgCount = CNT_BITS'(cur_ff.pgCount - 1'b1);
        nxt_ff.periodCount = CNT_BITS'(cur_ff.periodCount - 1'b1);
        if (cur_ff.pgCount == '0)
        begin
          nxt_ff.drive = 1'b0;
          nxt_ff.pgState = optical_front_end_pkg::PG_OFF;
        end
      end

      // Dark for the rest of the period
      optical_front_end_pkg::PG_OFF:
      begin
        nxt_ff.periodCount = CNT_BITS'(cur_ff.periodCount - 1'b1);
        if (cur_ff.periodCount == '0)
          nxt_ff.pgState = optical_front_end_pkg::PG_IDLE;
      end
      default: nxt_ff.pgState = optical_front_end_pkg::PG_IDLE;
    endcase

    // Transimpedance step: static holds, automatic loads on init and steps
    if (!cur_ff.impHys[`TIM_AUTO_BIT] || cur_ff.initPulse)
      nxt_ff.step = cur_ff.impHys[`TIM_MSB-1:`TIM_LSB];
    else if (sumCurrentHigh && !sumCurrentLow && cur_ff.step != 2'h3)
      nxt_ff.step = 2'(cur_ff.step + 1'b1);
    else if (sumCurrentLow && !sumCurrentHigh && cur_ff.step != `RST_STEP)
      nxt_ff.step = 2'(cur_ff.step - 1'b1);

    // Selected step reaches the pin one clock later
    nxt_ff.tiSel = cur_ff.step;

    // Switching state from filtered difference comparator selects set
    nxt_ff.near = diffComparatorFiltered;
    if (cur_ff.near)
      nxt_ff.params = '{splitPoint: cur_ff.nearSplit, gainRatio: cur_ff.nearGain};
    else
      nxt_ff.params = '{splitPoint: cur_ff.farSplit, gainRatio: cur_ff.farGain};

    // Hysteresis settings; filtered levels route the side at the comparators
    nxt_ff.diffHys.diffHysteresisSel = cur_ff.impHys[`DIFF_HYSTERESIS_SEL_MSB:`DIFF_HYSTERESIS_SEL_LSB];
    nxt_ff.diffHys.sumHysteresisSel = 2'(warnComparatorFiltered);
    nxt_ff.diffHys.hysteresisDisable = cur_ff.impHys[`HYSTERESIS_DISABLE_BIT];

    // Sum comparators: shared width, filtered warn and fault levels
    nxt_ff.sumHys.diffHysteresisSel = {2'h0, warnComparatorFiltered, faultComparatorFiltered};
    nxt_ff.sumHys.sumHysteresisSel = cur_ff.sumHysSel;
    nxt_ff.sumHys.hysteresisDisable = cur_ff.impHys[`HYSTERESIS_DISABLE_BIT];
  end

  // ========================================================================
  // State register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // Bus channels open; pulse rate code 1, width code 0
      cur_ff <= '0;
      cur_ff.awReady <= 1'b1;
      cur_ff.wReady <= 1'b1;
      cur_ff.arReady <= 1'b1;
      cur_ff.pulseCfg <= `RST_PULSE;
      cur_ff.pgState <= optical_front_end_pkg::PG_IDLE;
    end
    else
      cur_ff <= nxt_ff;
  end

  // ========================================================================
  // Outputs straight from the state register
  assign s_axi_awready = cur_ff.awReady;
  assign s_axi_wready = cur_ff.wReady;
  assign s_axi_bvalid = cur_ff.bValid;
  assign s_axi_bresp = cur_ff.bResp;
  assign s_axi_arready = cur_ff.arReady;
  assign s_axi_rvalid = cur_ff.rValid;
  assign s_axi_rresp = cur_ff.rResp;
  assign s_axi_rdata = cur_ff.rData;

  // Emitter and analogue controls
  assign emitterDrivePin = cur_ff.drive;
  assign transimpedanceSel = cur_ff.tiSel;
  assign activeParams = cur_ff.params;
  assign diffHysteresis = cur_ff.diffHys;
  assign sumHysteresis = cur_ff.sumHys;
  assign nearRange = cur_ff.near;

endmodule

// ### hw/optical_front_end_defines.svh
// Offsets, field positions, reset values and timing counts for the optical front-end controller.
// Assumes a 10 MHz core clock and a 32-bit AXI4-Lite register port.
`ifndef OPTICAL_FRONT_END_DEFINES_SVH
`define OPTICAL_FRONT_END_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define OFS_FAR_SPLIT 8'h00
`define OFS_FAR_GAIN 8'h04
`define OFS_NEAR_SPLIT 8'h08
`define OFS_NEAR_GAIN 8'h0c
`define OFS_IMP_HYS 8'h10
`define OFS_SUM_HYS 8'h14
`define OFS_PULSE 8'h20
`define OFS_FRONT_CTRL 8'h40
`define OFS_FRONT_STAT 8'h44

// ==========================================================================
// Printed register indices (byte address is four times the index)
`define IDX_FAR_SPLIT 8'h00
`define IDX_FAR_GAIN 8'h01
`define IDX_NEAR_SPLIT 8'h02
`define IDX_NEAR_GAIN 8'h03
`define IDX_IMP_HYS 8'h04
`define IDX_SUM_HYS 8'h05
`define IDX_PULSE 8'h08

// ==========================================================================
// Field positions
`define PULSE_OK_BIT 0
`define PER_LSB 4
`define PER_MSB 5
`define PW_LSB 0
`define PW_MSB 3
`define TIM_LSB 5
`define TIM_MSB 7
`define TIM_AUTO_BIT 7
`define HYSTERESIS_DISABLE_BIT 4
`define DIFF_HYSTERESIS_SEL_LSB 0
`define DIFF_HYSTERESIS_SEL_MSB 3
`define SUM_HYSTERESIS_LSB 6
`define SUM_HYSTERESIS_MSB 7
`define CTRL_LOWSIDE_BIT 0
`define CTRL_INIT_BIT 1

// ==========================================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_PULSE 6'h10
`define RST_STEP 2'h0

// ==========================================================================
// Timing: pulse width 2 us base plus 0.5 us per code, periods of each rate
`define CLK_NS 100
`define PW_BASE_NS 2000
`define PW_STEP_NS 500
`define PERIOD1_NS 71942
`define PERIOD2_NS 96154
`define PERIOD3_NS 200000
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ### hw/optical_front_end_pkg.sv
// Types for the optical front-end controller.
// Assumes the defines header is compiled alongside.
package optical_front_end_pkg;

  // Active parameter set driven to the analogue chain
  typedef struct packed {
    logic [6:0] splitPoint;
    logic [7:0] gainRatio;
  } param_set_s;

  // Comparator hysteresis controls
  typedef struct packed {
    logic [3:0] diffHysteresisSel;
    logic [1:0] sumHysteresisSel;
    logic hysteresisDisable;
  } hys_ctrl_s;

  // Pulse generator states, Gray along idle -> on -> off
  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_ON = 2'b01,
    PG_OFF = 2'b11
  } pulse_state_e;

endpackage

// ### test/front_end_checker.sv
// Concurrent checks on the ports of the optical front-end controller.
// Assumes one clock, core_clk, and the active-low asynchronous reset resetn.
module front_end_checker #(
  parameter int PW_BITS = 4,
  parameter int CNT_BITS = 12
) (
  // Clock and reset
  input logic core_clk,
  input logic resetn,
  // Register bus
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  // Analogue side
  input logic diffComparatorFiltered,
  input logic warnComparatorFiltered,
  input logic faultComparatorFiltered,
  input logic sumCurrentHigh,
  input logic sumCurrentLow,
  input logic emitterDrivePin,
  input logic [1:0] transimpedanceSel,
  input optical_front_end_pkg::param_set_s activeParams,
  input optical_front_end_pkg::hys_ctrl_s diffHysteresis,
  input optical_front_end_pkg::hys_ctrl_s sumHysteresis,
  input logic nearRange
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // Helper logic
  logic [7:0] onCnt_ff;
  logic [7:0] nxt_onCnt;
  logic stepReq;
  // A lone monitor crossing asks for one step
  assign stepReq = sumCurrentHigh ^ sumCurrentLow;
  // Clocks spent in the current light pulse
  assign nxt_onCnt = emitterDrivePin ? onCnt_ff + 8'h01 : 8'h00;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      onCnt_ff <= 8'h00;
    else
      onCnt_ff <= nxt_onCnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ========
  // Properties
  property p_near_follow;
    $changed(diffComparatorFiltered) |=> nearRange == $past(diffComparatorFiltered);
  endproperty
  a_near_follow: assert property (p_near_follow) else $error("near flag lost");
  property p_param_cause;
    $changed(activeParams) |-> $past(nearRange) != $past(nearRange, 2) || $past(s_axi_bvalid);
  endproperty
  a_param_cause: assert property (p_param_cause) else $error("set moved alone");
  property p_step_cause;
    $changed(transimpedanceSel) |-> $past(stepReq, 2) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)
      || $past(s_axi_bvalid, 3);
  endproperty
  a_step_cause: assert property (p_step_cause) else $error("step moved alone");
  property p_pulse_len;
    $fell(emitterDrivePin) |-> onCnt_ff >= 8'h14 && onCnt_ff <= 8'h5f;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length off");
  property p_warn_hys;
    $changed(warnComparatorFiltered) |=> sumHysteresis.diffHysteresisSel[1] == $past(warnComparatorFiltered)
      && diffHysteresis.sumHysteresisSel[0] == $past(warnComparatorFiltered);
  endproperty
  a_warn_hys: assert property (p_warn_hys) else $error("warn hysteresis");
  property p_fault_hys;
    $changed(faultComparatorFiltered) |=> sumHysteresis.diffHysteresisSel[0] == $past(faultComparatorFiltered);
  endproperty
  a_fault_hys: assert property (p_fault_hys) else $error("fault hysteresis");
  property p_dis_same;
    diffHysteresis.hysteresisDisable == sumHysteresis.hysteresisDisable;
  endproperty
  a_dis_same: assert property (p_dis_same) else $error("disable differs");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("response repeated");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read not answered");
  property p_r_data;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (s_axi_rresp != 2'b10 || s_axi_rdata == 32'h0);
  endproperty
  a_r_data: assert property (p_r_data) else $error("read data bits");
  // Main scenarios reached
  c_near: cover property ($rose(nearRange));
  c_pulse: cover property ($fell(emitterDrivePin));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

bind optical_pulse_front_end_ctrl front_end_checker #(.PW_BITS(PW_BITS), .CNT_BITS(CNT_BITS)) chkInst (.*);

// ### test/front_end_afe_model.sv
// Behavioural emitter and photodiode front end facing the controller.
// Assumes the bench places the light spot and sets the received level.
module front_end_afe_model (
  // Clock
  input logic core_clk,
  // Bench controls
  input logic emitterHealthy,
  input int objectDiode,
  input int lightLevel,
  // From the controller
  input logic emitterDrivePin,
  input optical_front_end_pkg::param_set_s activeParams,
  // To the controller
  output logic emitterCurrentSense,
  output logic diffComparatorFiltered,
  output logic warnComparatorFiltered,
  output logic faultComparatorFiltered,
  output logic sumCurrentHigh,
  output logic sumCurrentLow
);
  timeunit 1ns;
  timeprecision 1ns;
  // Current flows only in a pulse through a sound emitter
  assign emitterCurrentSense = emitterDrivePin & emitterHealthy;
  // Fixed sum monitor levels
  assign sumCurrentHigh = lightLevel > 90;
  assign sumCurrentLow = lightLevel < 5;
  // Filtered comparators settle one clock after a change
  initial
  begin
    {diffComparatorFiltered, warnComparatorFiltered, faultComparatorFiltered} = 3'h0;
  end
  always @(posedge core_clk)
  begin
    diffComparatorFiltered <= objectDiode <= int'(activeParams.splitPoint);
    warnComparatorFiltered <= lightLevel >= 40;
    faultComparatorFiltered <= lightLevel >= 20;
  end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the optical front-end controller.
// Assumes the design, its package and header, the checker and the front-end model.
`include "optical_front_end_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // Signals
  logic core_clk = 1'b0, resetn = 1'b0, emitterHealthy = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, transimpedanceSel;
  logic emitterCurrentSense, diffComparatorFiltered, warnComparatorFiltered, faultComparatorFiltered;
  logic sumCurrentHigh, sumCurrentLow, emitterDrivePin, nearRange;
  optical_front_end_pkg::param_set_s activeParams;
  optical_front_end_pkg::hys_ctrl_s diffHysteresis, sumHysteresis;
  int objectDiode = 127, lightLevel = 50, seed = 69, err_count = 0, n_compared = 0;
  int regModel [int];
  logic [7:0] maps [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  real hz [4] = '{1.0, 13.9e3, 10.4e3, 5.0e3};
  optical_pulse_front_end_ctrl uut (.*);
  front_end_afe_model afe (.*);
  // Clock of 100 ns
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  // ========
  // Checks and bus tasks
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
    n_compared++;
    if ($isunknown(got) || (got !== exp && (tol == 0 || got > exp + tol || got < exp - tol)))
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] expRead(input logic [7:0] a, input logic good);
    logic [7:0] m;
    case (a)
      8'h00, 8'h08: m = 8'h7f;
      8'h14: m = 8'hc0;
      8'h20: m = 8'h3e;
      default: m = 8'hff;
    endcase
    return {24'h0, regModel[a][7:0] & m} | 32'(a == `OFS_PULSE && good);
  endfunction
  task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = `AXI_OKAY,
    input logic [3:0] s = 4'h1);
    logic [31:0] r;
    int n;
    r = $random(seed);
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {r[31:8], d};
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    chkVal(32'({s_axi_bvalid, s_axi_bresp}), 32'({1'b1, er}));
    if (er == `AXI_OKAY && s[0]) regModel[a] = d;
  endtask
  task automatic axiRead(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chkVal(32'({s_axi_rvalid, s_axi_rresp}), 32'({1'b1, er}));
  endtask
  task automatic readCheck(input logic [7:0] a, input logic good = 1'b0);
    logic [31:0] d;
    axiRead(a, `AXI_OKAY, d);
    chkVal(d, expRead(a, good));
  endtask
  // Waits for the next light pulse, giving its start cycle and length
  task automatic waitPulse(output int tRise, output int len);
    int n;
    n = 0;
    len = 0;
    @(posedge core_clk);
    while (emitterDrivePin !== 1'b1 && n < 2500)
    begin
      @(posedge core_clk);
      n++;
    end
    tRise = int'($time / 100);
    while (emitterDrivePin === 1'b1 && len < 200)
    begin
      @(posedge core_clk);
      len++;
    end
  endtask
  task automatic bump(input int lvl);
    @(posedge core_clk);
    lightLevel <= lvl;
    @(posedge core_clk);
    lightLevel <= 50;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hang short
  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
  // ========
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [7:0] h;
    int t0, t1, w, s, far, near, gf, gn;
    foreach (maps[i]) regModel[maps[i]] = 0;
    regModel[`OFS_PULSE] = 32'h10;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (maps[i]) readCheck(maps[i]);
    axiRead(8'h30, `AXI_SLVERR, d);
    axiWrite(8'h30, 8'hff, `AXI_SLVERR);
    foreach (maps[i]) axiWrite(maps[i], 8'($random(seed)));
    foreach (maps[i]) axiWrite(maps[i], 8'h5a, `AXI_OKAY, 4'he);
    foreach (maps[i]) readCheck(maps[i]);
    // Current monitor: output mode, faulty and sound emitter in low-side mode
    axiWrite(`OFS_PULSE, 8'h10);
    for (int k = 0; k < 3; k++)
    begin
      emitterHealthy <= (k != 1);
      axiWrite(`OFS_FRONT_CTRL, 8'(k > 0));
      repeat (2) waitPulse(t0, w);
      readCheck(`OFS_PULSE, k == 2);
    end
    // Pulse length and repetition for each rate code
    for (int r = 3; r >= 0; r--)
    begin
      s = $random(seed) & 15;
      axiWrite(`OFS_PULSE, 8'(r * 16 + s));
      repeat (2) waitPulse(t0, w);
      waitPulse(t1, w);
      if (r == 0)
        chkVal(32'(w), 32'h0);
      else
      begin
        chkVal(32'(w), 32'(20 + 5 * s));
        chkVal(32'(t1 - t0), 32'($rtoi(1.0e7 / hz[r] + 0.5)), 2);
      end
    end
    // Static and automatic impedance steps
    for (int c = 0; c < 8; c++)
    begin
      s = c % 4;
      axiWrite(`OFS_IMP_HYS, 8'(c * 32));
      axiWrite(`OFS_FRONT_CTRL, 8'h3);
      repeat (4) @(posedge core_clk);
      chkVal(32'(transimpedanceSel), 32'(s));
      axiRead(`OFS_FRONT_STAT, `AXI_OKAY, d);
      chkVal(d & 32'h6, 32'(s * 2));
      bump(s < 3 ? 95 : 2);
      chkVal(32'(transimpedanceSel), 32'(c < 4 ? s : (s < 3 ? s + 1 : 2)));
    end
    // Hysteresis fields and the two parameter sets
    for (int k = 0; k < 2; k++)
    begin
      h = $random(seed);
      far = $random(seed) & 63;
      near = far + ($random(seed) & 63);
      gf = $random(seed) & 255;
      gn = $random(seed) & 255;
      axiWrite(`OFS_IMP_HYS, {3'h0, 1'(k), h[3:0]});
      axiWrite(`OFS_SUM_HYS, h);
      axiWrite(`OFS_FAR_SPLIT, 8'(far));
      axiWrite(`OFS_FAR_GAIN, 8'(gf));
      axiWrite(`OFS_NEAR_SPLIT, 8'(near));
      axiWrite(`OFS_NEAR_GAIN, 8'(gn));
      bump(2);
      chkVal(32'({diffHysteresis.diffHysteresisSel, sumHysteresis.sumHysteresisSel, diffHysteresis.hysteresisDisable,
        sumHysteresis.hysteresisDisable}), 32'({h[3:0], h[7:6], 1'(k), 1'(k)}));
      chkVal(32'({nearRange, activeParams}), 32'({1'b0, 7'(far), 8'(gf)}));
      objectDiode <= 0;
      repeat (5) @(posedge core_clk);
      chkVal(32'({nearRange, activeParams}), 32'({1'b1, 7'(near), 8'(gn)}));
      objectDiode <= 127;
      repeat (5) @(posedge core_clk);
    end
    print_verdict();
  end
endmodule
